// File: bench/prfs_properties.sv
// checker: handshake, filtering, framing and time base properties
`timescale 1ns/1ns
`include "prfs_regs.vh"
module prfs_props (
	input wire        clk,
	input wire        srst,
	input wire        meas_valid,
	input wire [7:0]  fix_quality,
	input wire        reliable_only_setting,
	input wire        stuffing_enable,
	input wire        byte_ready,
	input wire        byte_valid,
	input wire [7:0]  byte_data,
	input wire        byte_last,
	input wire        busy,
	input wire [31:0] epoch_seconds,
	input wire [9:0]  epoch_millis
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire good  = fix_quality == `PRFS_LOCK_GOOD;  // reliable lock
	wire inner = stuffing_enable && byte_valid && !byte_last;  // body byte
	property p_end;
		byte_valid && byte_last |-> byte_data == `PRFS_END_MARK &&
			(!busy || $past(byte_valid && byte_last));
	endproperty
	a_end: assert property (p_end) else $error("bad end byte");
	property p_take;
		meas_valid && !busy && (good || !reliable_only_setting)
			|=> busy ##1 byte_valid;
	endproperty
	a_take: assert property (p_take) else $error("not taken");
	property p_drop;
		meas_valid && !busy && !good && reliable_only_setting |=> !busy;
	endproperty
	a_drop: assert property (p_drop) else $error("not dropped");
	property p_hold;
		byte_valid && !byte_ready
			|=> byte_valid && $stable(byte_data) && $stable(byte_last);
	endproperty
	a_hold: assert property (p_hold) else $error("byte lost");
	property p_rst;
		disable iff (1'b0) srst |=> !busy && !byte_valid
			&& epoch_seconds == 32'h0 && epoch_millis == 10'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_ms;
		epoch_millis <= `PRFS_MS_MAX;
	endproperty
	a_ms: assert property (p_ms) else $error("millis range");
	property p_stuff;
		inner |-> byte_data != `PRFS_END_MARK
			&& byte_data != `PRFS_START_MARK;
	endproperty
	a_stuff: assert property (p_stuff) else $error("raw mark");
	property p_esc;
		inner && byte_ready && byte_data == `PRFS_ESC_MARK
			|=> byte_valid && byte_data inside {8'h5D, 8'h5E, 8'h5F};
	endproperty
	a_esc: assert property (p_esc) else $error("bad escape");
endmodule // prfs_props
bind prfs_serializer prfs_props i_prfs_props (.clk(clk), .srst(srst),
	.meas_valid(meas_valid), .fix_quality(fix_quality),
	.reliable_only_setting(reliable_only_setting),
	.stuffing_enable(stuffing_enable), .byte_ready(byte_ready),
	.byte_valid(byte_valid), .byte_data(byte_data), .byte_last(byte_last),
	.busy(busy), .epoch_seconds(epoch_seconds), .epoch_millis(epoch_millis));

// File: bench/prfs_sink.sv
// partner: byte sink that stalls on request and undoes stuffing
`timescale 1ns/1ns
module prfs_sink (
	input wire       clk,
	input wire       clr,
	input wire       slow,
	input wire       stuffing_enable,
	input wire       byte_valid,
	input wire [7:0] byte_data,
	input wire       byte_last,
	output reg       byte_ready
);
	reg [7:0] pkt [0:127];  // received bytes, unstuffed
	integer   n = 0;        // bytes since clear
	reg       esc = 1'b0;   // escape byte pending
	reg [1:0] ph = 2'h0;    // stall phase
	initial byte_ready = 1'b0;
	// ready drops one cycle in four when slow, so holding is exercised
	always @(posedge clk)
	begin
		ph <= ph + 2'h1;
		byte_ready <= !slow || ph != 2'h0;
		if (clr)
		begin
			n   <= 0;
			esc <= 1'b0; // a cut packet must not leave an escape pending
		end
		else if (byte_valid && byte_ready)
		begin
			if (stuffing_enable && !byte_last && !esc && byte_data == 8'h7D)
				esc <= 1'b1;
			else
			begin
				pkt[n] <= esc ? byte_data ^ 8'h20 : byte_data;
				n <= n + 1;
				esc <= 1'b0;
			end
		end
	end
endmodule // prfs_sink

// File: bench/testbench.sv
// testbench: field order, byte order, stuffing and filtering
`timescale 1ns/1ns
`include "prfs_regs.vh"
module testbench;
	reg clk, srst, meas_valid, clr, slow, fault_overflow, stuffing_enable;
	reg [31:0] coord_x, coord_y, x_speed, y_speed, cu_x, cu_y, su_x, su_y;
	reg [15:0] heading, hu;
	reg [7:0] fix_quality;
	reg [63:0] app_payload;
	reg [39:0] fault_codes;
	reg [79:0] fault_values;
	reg [4:0] fault_active;
	reg [8:0] en;  // field enables, time field in bit 0
	reg rel;
	wire byte_ready, byte_valid, byte_last, busy;
	wire [7:0] byte_data;
	wire [31:0] epoch_seconds;
	wire [9:0] epoch_millis;
	integer failures, checked, i, k;
	reg [7:0] q [$];
	// rows: stuffing, reliable only, fix quality, enables
	reg [12:0] rows [0:5] = '{13'h1DFF, 13'h1C02, 13'h1303, 13'h01FF,
		13'h1CAA, 13'h1D55};
	prfs_serializer i_prfs_serializer (.clk(clk), .srst(srst),
		.meas_valid(meas_valid), .coord_x(coord_x), .coord_y(coord_y),
		.fix_quality(fix_quality), .x_speed(x_speed), .y_speed(y_speed),
		.heading(heading), .coord_uncert_x(cu_x), .coord_uncert_y(cu_y),
		.x_speed_uncertainty(su_x), .y_speed_uncertainty(su_y),
		.heading_uncertainty(hu), .app_payload(app_payload),
		.fault_codes(fault_codes), .fault_values(fault_values),
		.fault_active(fault_active), .fault_overflow(fault_overflow),
		.time_field_enable(en[0]), .coord_field_enable(en[1]),
		.speed_field_enable(en[2]), .heading_field_enable(en[3]),
		.coord_uncert_enable(en[4]), .speed_uncert_enable(en[5]),
		.heading_uncert_enable(en[6]), .app_payload_enable(en[7]),
		.fault_list_enable(en[8]), .reliable_only_setting(rel),
		.stuffing_enable(stuffing_enable), .byte_ready(byte_ready),
		.byte_valid(byte_valid), .byte_data(byte_data),
		.byte_last(byte_last), .busy(busy),
		.epoch_seconds(epoch_seconds), .epoch_millis(epoch_millis));
	prfs_sink i_prfs_sink (.clk(clk), .clr(clr), .slow(slow),
		.stuffing_enable(stuffing_enable), .byte_valid(byte_valid),
		.byte_data(byte_data), .byte_last(byte_last),
		.byte_ready(byte_ready));
	initial begin clk = 0; forever #2 clk = ~clk; end
	task chk(input string name, input [63:0] seen, input [63:0] exp);
	begin
		checked = checked + 1;
		if (seen !== exp)
		begin
			failures = failures + 1;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	end
	endtask
	task close_out;
	begin
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask
	// expected bytes, high byte first
	task put(input [71:0] v, input integer nb);
		integer j;
		for (j = nb - 1; j >= 0; j--) q.push_back(v[8*j+:8]);
	endtask
	// one packet; meas_valid held two edges, the second falls while busy
	task pkt(input [12:0] r);
		integer s;
	begin
		{stuffing_enable, rel} <= r[12:11];
		fix_quality <= {6'h00, r[10:9]};
		en <= r[8:0];
		fault_overflow <= i[0];
		fault_active <= i[0] ? 5'h1F : 5'h0A;
		slow <= i[1];
		clr <= 1;
		meas_valid <= 1;
		@(posedge clk);
		clr <= 0;
		q = {};
		if (en[0]) put(0, 6);
		if (en[1]) put({coord_x, coord_y, fix_quality}, 9);
		if (en[2]) put({x_speed, y_speed}, 8);
		if (en[3]) put(heading, 2);
		if (en[4]) put({cu_x, cu_y}, 8);
		if (en[5]) put({su_x, su_y}, 8);
		if (en[6]) put(hu, 2);
		if (en[7]) put(app_payload, 8);
		if (en[8])
			for (k = 0; k < 5; k++)
				put({k == 4 && fault_overflow ? 8'hFF : fault_active[k] ?
					fault_codes[8*k+:8] : 8'h00, fault_active[k] ?
					fault_values[16*k+:16] : 16'h0000}, 3);
		put(`PRFS_END_MARK, 1);
		@(posedge clk);
		meas_valid <= 0;
		#1;
		for (s = 0; s < 400 && !(byte_valid && byte_ready && byte_last); s++)
			@(posedge clk) #1;
		@(posedge clk) #1;
		chk("end seen", s < 400, 1);
		chk("length", i_prfs_sink.n, q.size());
		for (k = 0; k < q.size(); k++)
			chk("byte", i_prfs_sink.pkt[k], q[k]);
		$display("packet %0d done", i);
	end
	endtask
	initial begin #40000; failures = failures + 1; close_out; end
	initial
	begin
		failures = 0; checked = 0; srst = 1; meas_valid = 0; clr = 0;
		slow = 0; en = 0; rel = 1; stuffing_enable = 1; fix_quality = 0;
		fault_overflow = 0; fault_active = 0;
		{coord_x, coord_y} = 64'h7F017E02_80037D04;
		{x_speed, y_speed} = 64'hFFFFFF85_01020304;
		{cu_x, cu_y} = 64'h00007E10_11121314;
		{su_x, su_y} = 64'h21227D24_31323334;
		{heading, hu} = 32'h0167_007F;
		app_payload = 64'h7E7D7F00_11223344;
		fault_codes = 40'h55667F7899;
		fault_values = 80'h0102_0304_7E06_0708_090A;
		repeat (4) @(posedge clk);
		srst <= 0;
		@(posedge clk) #1;
		chk("busy", {busy, byte_valid, epoch_seconds}, 0);
		$display("reset test done");
		for (i = 0; i < 6; i++)
		begin
			@(posedge clk);
			pkt(rows[i]);
		end
		@(posedge clk);
		{rel, fix_quality, clr, meas_valid} <= {1'b1, 8'h01, 2'h3};
		@(posedge clk);
		{clr, meas_valid} <= 2'h0;
		repeat (4) @(posedge clk);
		#1 chk("dropped", {busy, i_prfs_sink.n}, 0);
		$display("unreliable fix test done");
		// cut a packet by reset, then check a clean packet follows
		@(posedge clk);
		rel <= 0;
		meas_valid <= 1;
		@(posedge clk);
		meas_valid <= 0;
		repeat (5) @(posedge clk);
		srst <= 1;
		repeat (2) @(posedge clk);
		srst <= 0;
		#1 chk("cut", {busy, byte_valid, epoch_seconds, epoch_millis}, 0);
		$display("mid-run reset test done");
		@(posedge clk);
		pkt(rows[0]);
		close_out;
	end
endmodule // testbench

// File: rtl/prfs_regs.vh
// constants for the position report field serializer
`ifndef PRFS_REGS_VH
`define PRFS_REGS_VH
`define PRFS_END_MARK     8'h7F
`define PRFS_START_MARK   8'h7E
`define PRFS_ESC_MARK     8'h7D
`define PRFS_ESC_XOR      8'h20
`define PRFS_OVF_CODE     8'hFF
`define PRFS_LOCK_GOOD    8'h02
`define PRFS_MS_MAX       10'h3E7
`define PRFS_CLK_MHZ      250
`define PRFS_MS_NS        1000000
`define PRFS_CLK_NS       4
`define PRFS_MS_CYC       18'h3D090
`define PRFS_ERR_SLOTS    5
`define PRFS_F_TIME       0
`define PRFS_F_COORD      1
`define PRFS_F_SPEED      2
`define PRFS_F_HEAD       3
`define PRFS_F_CUNC       4
`define PRFS_F_SUNC       5
`define PRFS_F_HUNC       6
`define PRFS_F_APP        7
`define PRFS_F_FAULT      8
`define PRFS_F_END        9
`endif

// File: rtl/prfs_serializer.v
// position report field serializer: payload fields, stuffing, end marker
`timescale 1ns/1ns
// How it works
// - close every packet with end byte 7F
// - timestamp: 4-byte seconds, 2-byte millis
// - time base restarts at zero on reset
// - timestamp latched at measurement, not transmission
// - position: x, y signed, lock byte
// - lock 0/1 unreliable, 2 reliable
// - reliable only unless setting cleared
// - position field on unless enable cleared
// - velocity: x, y signed 4-byte each
// - heading: 2-byte angle, 0 to 359
// - position uncertainty: two unsigned 4-byte
// - velocity uncertainty: two unsigned 4-byte
// - heading uncertainty: one 2-byte value
// - user data: 8-byte opaque value
// - fault list: five slots code plus value
// - active faults reported in every packet
// - more than five faults: slot five FF
// - optional fields sent only when enabled
// - multi-byte integers sent high byte first
// - fields in fixed order
// - escape reserved bytes with 7D, xor 20
`include "prfs_regs.vh"
module prfs_serializer (
	input  wire        clk,
	input  wire        srst,
	input  wire        meas_valid,          // one-cycle pulse: new measurement
	input  wire [31:0] coord_x,
	input  wire [31:0] coord_y,
	input  wire [7:0]  fix_quality,
	input  wire [31:0] x_speed,
	input  wire [31:0] y_speed,
	input  wire [15:0] heading,
	input  wire [31:0] coord_uncert_x,
	input  wire [31:0] coord_uncert_y,
	input  wire [31:0] x_speed_uncertainty,
	input  wire [31:0] y_speed_uncertainty,
	input  wire [15:0] heading_uncertainty,
	input  wire [63:0] app_payload,
	input  wire [39:0] fault_codes,         // five codes, slot 1 in low byte
	input  wire [79:0] fault_values,        // five values, slot 1 low
	input  wire [4:0]  fault_active,        // per-slot active flags
	input  wire        fault_overflow,      // more than five faults active
	input  wire        time_field_enable,
	input  wire        coord_field_enable,
	input  wire        speed_field_enable,
	input  wire        heading_field_enable,
	input  wire        coord_uncert_enable,
	input  wire        speed_uncert_enable,
	input  wire        heading_uncert_enable,
	input  wire        app_payload_enable,
	input  wire        fault_list_enable,
	input  wire        reliable_only_setting,
	input  wire        stuffing_enable,
	input  wire        byte_ready,
	output reg         byte_valid,
	output reg  [7:0]  byte_data,
	output reg         byte_last,
	output reg         busy,
	output reg  [31:0] epoch_seconds,
	output reg  [9:0]  epoch_millis
);

	// ****************************************************************
	// time base
	// ****************************************************************
	// cycles per millisecond, sized to the counter so nothing is cut
	localparam [17:0] MS_CYC = `PRFS_MS_CYC;
	reg  [17:0] tick_cnt_r;                 // cycles within a millisecond

	// counts from zero after every reset: no battery clock here
	always @(posedge clk)
	begin
		if (srst)
		begin
			tick_cnt_r    <= 18'h00000;
			epoch_millis  <= 10'h000;
			epoch_seconds <= 32'h00000000;
		end
		else if (tick_cnt_r == MS_CYC - 18'h00001)
		begin
			tick_cnt_r <= 18'h00000;
			if (epoch_millis == `PRFS_MS_MAX)
			begin
				epoch_millis  <= 10'h000;
				epoch_seconds <= epoch_seconds + 32'h00000001;
			end
			else
				epoch_millis <= epoch_millis + 10'h001;
		end
		else
			tick_cnt_r <= tick_cnt_r + 18'h00001;
	end

	// ****************************************************************
	// snapshot of one measurement
	// ****************************************************************
	reg [527:0] snap_r;                     // all 66 field bytes, packed
	reg [9:0]   en_r;                       // field enables, end forced on

	// field start byte offsets inside snap_r (msb of each field)
	function [8:0] fld_len;                 // field length in bytes
		input [3:0] f;
		begin
			case (f)
			4'd0:    fld_len = 9'd6;
			4'd1:    fld_len = 9'd9;
			4'd2:    fld_len = 9'd8;
			4'd3:    fld_len = 9'd2;
			4'd4:    fld_len = 9'd8;
			4'd5:    fld_len = 9'd8;
			4'd6:    fld_len = 9'd2;
			4'd7:    fld_len = 9'd8;
			4'd8:    fld_len = 9'd15;
			default: fld_len = 9'd1;
			endcase
		end
	endfunction

	// fault slot i: code or zero, overflow code into slot five
	function [23:0] slot;
		input [2:0] i;
		reg   [7:0] c;
		reg  [15:0] v;
		begin
			c = fault_codes[i*8 +: 8];
			v = fault_values[i*16 +: 16];
			if (!fault_active[i])
				slot = 24'h000000;
			else
				slot = {c, v};
			if (i == 3'd4 && fault_overflow)
				slot = {`PRFS_OVF_CODE, slot[15:0]};
		end
	endfunction

	wire lock_ok = (fix_quality == `PRFS_LOCK_GOOD);
	// a new packet is started only if the lock gate allows it
	wire take = meas_valid && !busy &&
		(lock_ok || !reliable_only_setting);

	// ****************************************************************
	// packet state machine
	// ****************************************************************
	localparam [2:0] S_IDLE = 3'b001;
	localparam [2:0] S_DATA = 3'b010;
	localparam [2:0] S_ESC  = 3'b100;
	reg  [2:0]  state_r;
	reg  [3:0]  fld_r;                      // current field index
	reg  [8:0]  idx_r;                      // byte within field
	reg  [8:0]  base_r;                     // byte offset of field in snap
	reg  [7:0]  raw;                        // unstuffed current byte
	reg  [8:0]  pos;                        // absolute byte index
	reg  [3:0]  nf;                         // next enabled field
	integer     k;

	always @*
	begin
		pos = base_r + idx_r;
		raw = snap_r[527 - pos*8 -: 8];
		if (fld_r == `PRFS_F_END)
			raw = `PRFS_END_MARK;
		nf = `PRFS_F_END;
		for (k = 8; k >= 0; k = k - 1)
			if (k > fld_r && en_r[k])
				nf = k[3:0];
	end

	wire is_rsv  = (raw == `PRFS_END_MARK) || (raw == `PRFS_START_MARK) ||
		(raw == `PRFS_ESC_MARK);
	wire need_es = stuffing_enable && is_rsv && fld_r != `PRFS_F_END;
	wire fld_end = (idx_r == fld_len(fld_r) - 9'd1);
	wire step    = !byte_valid || byte_ready;

	// first enabled field index at packet start
	function [3:0] first_fld;
		input [9:0] e;
		integer j;
		begin
			first_fld = `PRFS_F_END;
			for (j = 8; j >= 0; j = j - 1)
				if (e[j])
					first_fld = j[3:0];
		end
	endfunction

	function [8:0] base_of;
		input [3:0] f;
		integer j;
		begin
			base_of = 9'd0;
			for (j = 0; j < 9; j = j + 1)
				if (j < f)
					base_of = base_of + fld_len(j[3:0]);
		end
	endfunction

	wire [9:0] en_now = {1'b1, fault_list_enable, app_payload_enable,
		heading_uncert_enable, speed_uncert_enable, coord_uncert_enable,
		heading_field_enable, speed_field_enable, coord_field_enable,
		time_field_enable};

	// drives one byte per accepted handshake, escapes reserved bytes
	always @(posedge clk)
	begin
		if (srst)
		begin
			state_r    <= S_IDLE;
			fld_r      <= 4'h0;
			idx_r      <= 9'h000;
			base_r     <= 9'h000;
			snap_r     <= {528{1'b0}};
			en_r       <= 10'h000;
			byte_valid <= 1'b0;
			byte_data  <= 8'h00;
			byte_last  <= 1'b0;
			busy       <= 1'b0;
		end
		else
		begin
			if (byte_valid && byte_ready)
				byte_valid <= 1'b0;
			case (state_r)
			S_IDLE:
			begin
				if (take)
				begin
					// captured at measurement time, not at send
					snap_r <= {epoch_seconds, 6'h00, epoch_millis,
						coord_x, coord_y, fix_quality,
						x_speed, y_speed, heading,
						coord_uncert_x, coord_uncert_y,
						x_speed_uncertainty, y_speed_uncertainty,
						heading_uncertainty, app_payload,
						slot(3'd0), slot(3'd1), slot(3'd2),
						slot(3'd3), slot(3'd4)};
					en_r    <= en_now;
					fld_r   <= first_fld(en_now);
					base_r  <= base_of(first_fld(en_now));
					idx_r   <= 9'h000;
					busy    <= 1'b1;
					state_r <= S_DATA;
				end
			end
			S_DATA:
			begin
				if (step)
				begin
					byte_valid <= 1'b1;
					byte_last  <= 1'b0;
					if (need_es)
					begin
						byte_data <= `PRFS_ESC_MARK;
						state_r   <= S_ESC;
					end
					else
					begin
						byte_data <= raw;
						if (fld_r == `PRFS_F_END)
						begin
							byte_last <= 1'b1;
							busy      <= 1'b0;
							state_r   <= S_IDLE;
						end
						else if (fld_end)
						begin
							fld_r  <= nf;
							base_r <= base_of(nf);
							idx_r  <= 9'h000;
						end
						else
							idx_r <= idx_r + 9'h001;
					end
				end
			end
			S_ESC:
			begin
				if (step)
				begin
					byte_valid <= 1'b1;
					byte_data  <= raw ^ `PRFS_ESC_XOR;
					state_r    <= S_DATA;
					if (fld_end)
					begin
						fld_r  <= nf;
						base_r <= base_of(nf);
						idx_r  <= 9'h000;
					end
					else
						idx_r <= idx_r + 9'h001;
				end
			end
			default:
				state_r <= S_IDLE;
			endcase
		end
	end

endmodule // prfs_serializer
